/* src/pioc_pkg.sv */
// Constants and state types shared by the parallel I/O line controller.
// Assumes a 32-bit APB register bus and 32 lines, one per data bit.
package pioc_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_LINES = 32;                  // Lines handled
    localparam int AW        = 8;                   // APB byte address bits

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [AW-1:0] IO_SELECT_OFS     = 8'h00;  // Give lines to controller
    localparam logic [AW-1:0] HAND_OVER_OFS     = 8'h04;  // Give lines to peripheral
    localparam logic [AW-1:0] OWNER_STAT_OFS    = 8'h08;  // Owner status
    localparam logic [AW-1:0] DRIVE_EN_OFS      = 8'h10;  // Output enable set
    localparam logic [AW-1:0] DRIVE_DIS_OFS     = 8'h14;  // Output enable clear
    localparam logic [AW-1:0] DRIVE_STAT_OFS    = 8'h18;  // Output enable status
    localparam logic [AW-1:0] FILT_EN_OFS       = 8'h20;  // Glitch filter set
    localparam logic [AW-1:0] FILT_DIS_OFS      = 8'h24;  // Glitch filter clear
    localparam logic [AW-1:0] FILT_STAT_OFS     = 8'h28;  // Glitch filter status
    localparam logic [AW-1:0] LEVEL_SET_OFS     = 8'h30;  // Output data set
    localparam logic [AW-1:0] LEVEL_CLR_OFS     = 8'h34;  // Output data clear
    localparam logic [AW-1:0] LEVEL_STAT_OFS    = 8'h38;  // Output data, direct write
    localparam logic [AW-1:0] PIN_LEVEL_OFS     = 8'h3C;  // Sampled pin levels
    localparam logic [AW-1:0] CHG_EN_OFS        = 8'h40;  // Change mask set
    localparam logic [AW-1:0] CHG_DIS_OFS       = 8'h44;  // Change mask clear
    localparam logic [AW-1:0] CHG_MASK_OFS      = 8'h48;  // Change mask status
    localparam logic [AW-1:0] CHG_STAT_OFS      = 8'h4C;  // Change status, read clears
    localparam logic [AW-1:0] MDRV_EN_OFS       = 8'h50;  // Multi-drive set
    localparam logic [AW-1:0] MDRV_DIS_OFS      = 8'h54;  // Multi-drive clear
    localparam logic [AW-1:0] MDRV_STAT_OFS     = 8'h58;  // Multi-drive status
    localparam logic [AW-1:0] PULLUP_DIS_OFS    = 8'h60;  // Pull-up off
    localparam logic [AW-1:0] PULLUP_EN_OFS     = 8'h64;  // Pull-up on
    localparam logic [AW-1:0] PULLUP_STAT_OFS   = 8'h68;  // Pull-up status, 1 = off
    localparam logic [AW-1:0] FUNC_A_OFS        = 8'h70;  // Select function A
    localparam logic [AW-1:0] FUNC_B_OFS        = 8'h74;  // Select function B
    localparam logic [AW-1:0] FUNC_AB_STAT_OFS  = 8'h78;  // A/B status, 1 = B
    localparam logic [AW-1:0] DWR_EN_OFS        = 8'hA0;  // Direct write mask set
    localparam logic [AW-1:0] DWR_DIS_OFS       = 8'hA4;  // Direct write mask clear
    localparam logic [AW-1:0] DWR_MASK_OFS      = 8'hA8;  // Direct write mask status

    // ************************************************************
    // Product-level line options and reset values
    // ************************************************************
    localparam logic [31:0] LINE_MUXED_MASK = 32'hFFFF_FFFF; // 1 = line has a peripheral
    localparam logic [31:0] OWNER_RST       = 32'hFFFF_FFFF; // 0 = peripheral from reset
    localparam logic [31:0] ZERO_RST        = 32'h0000_0000; // Common all-zero reset

    // ************************************************************
    // State types
    // ************************************************************
    typedef struct packed {
        logic [31:0] val;                           // Status bits
    } pioc_sc_s;

    typedef struct packed {
        logic [31:0] raw;                           // Previous raw sample
        logic [31:0] lvl;                           // Accepted pin level
        logic [31:0] chg;                           // Change pulse per line
    } pioc_smp_s;

    typedef struct packed {
        logic [31:0] chg_stat;                      // Sticky change flags
        logic        irq;                           // Interrupt output
        logic [31:0] rdata;                         // Read data for access phase
        logic        slverr;                        // Error for access phase
    } pioc_top_s;

endpackage

/* src/pioc_setclr_reg.sv */
// One 32-bit status register driven by set, clear and masked direct writes.
// Assumes strobes are one-cycle pulses in the register bus clock domain.
`timescale 1ns/1ns
module pioc_setclr_reg
    import pioc_pkg::*;
#(
    parameter logic [31:0] RST_VAL = 32'h0000_0000    // Value after reset
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    // Update requests
    input  wire logic [31:0] set_i,                // Bits to set
    input  wire logic [31:0] clr_i,                // Bits to clear
    input  wire logic [31:0] wmask_i,              // Bits to load directly
    input  wire logic [31:0] wdata_i,              // Direct load data
    // Status
    output logic      [31:0] val_o                 // Current status
);

    pioc_sc_s st_q;                                 // Registered state
    pioc_sc_s st_d;                                 // Next state

    // Set wins over clear should both ever arrive together
    always_comb begin
        st_d     = st_q;
        st_d.val = (st_q.val & ~wmask_i) | (wdata_i & wmask_i);
        st_d.val = (st_d.val & ~clr_i) | set_i;
    end

    // Synchronous reset to the product value
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_q.val <= RST_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign val_o = st_q.val;

endmodule

/* src/pioc_in_sample.sv */
// Pin sampling, optional glitch filter and change detection for 32 lines.
// Assumes pad inputs are synchronous to mclk_i; runs only while smp_en_i is high.
`timescale 1ns/1ns
module pioc_in_sample
    import pioc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    // Control
    input  wire logic        smp_en_i,             // Peripheral clock running
    input  wire logic [31:0] filt_en_i,            // Filter enable per line
    input  wire logic [31:0] pad_in_i,             // Pad levels
    // Results
    output logic      [31:0] level_o,              // Accepted levels
    output logic      [31:0] change_o              // One-cycle change pulses
);

    pioc_smp_s st_q;                                // Registered state
    pioc_smp_s st_d;                                // Next state

    // A filtered line takes the previous sample: one cycle of latency, and
    // a pulse of one cycle or longer still gets through to the level
    always_comb begin
        st_d     = st_q;
        st_d.chg = '0;
        if (smp_en_i) begin
            st_d.raw = pad_in_i;
            st_d.lvl = (filt_en_i & st_q.raw) | (~filt_en_i & pad_in_i);
            st_d.chg = st_d.lvl ^ st_q.lvl;
        end
    end

    // Levels freeze while sampling is stopped
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o  = st_q.lvl;
    assign change_o = st_q.chg;

endmodule

/* src/pioc_top.sv */
// Parallel I/O line controller: APB registers, line ownership and pad drive.
// Assumes an APB master on mclk_i, pads that resolve the drive enables, and
// a power manager that reports whether the controller clock is enabled.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns

// Operation
// - 32 lines, one bit each register
// - Pull-up enable clears, disable sets status
// - Pull-up writes act in any configuration
// - Pull-up status resets to zero
// - Select sets owner bit, hand-over clears it
// - Non-muxed lines ignore ownership, read one
// - Owner reset value is product parameter
// - A select clears, B sets; reset zero
// - Peripherals always see pin input level
// - A/B writes act in any ownership
// - Peripheral owns drive enable and level
// - Output enable/disable set drive status
// - Set/clear writes set driven level bits
// - Drive and level writes act always
// - Direct level write honours write mask
// - Mask set/clear, resets to zero
// - Register writes work with clock gated
// - Sampling and change only when clocked
// - Pin level reports pad, frozen when gated
// - Optional filter delays one cycle, passes pulses
// - Change sets flag; read clears; masked irq
// - Multi-drive only pulls low or releases
module pioc_top
    import pioc_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk_i,
    input  wire logic          rstn_i,
    // Power manager
    input  wire logic          per_clk_en_i,    // Controller clock enabled
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Pads
    input  wire logic [31:0]   pad_in_i,        // Pad input levels
    output logic      [31:0]   pad_out_o,       // Pad output levels
    output logic      [31:0]   pad_oe_n_o,      // Low while the line is driven
    output logic      [31:0]   pullup_en_o,     // High turns the pull-up on
    // Peripheral function A
    input  wire logic [31:0]   func_a_out_i,
    input  wire logic [31:0]   func_a_oe_i,
    // Peripheral function B
    input  wire logic [31:0]   func_b_out_i,
    input  wire logic [31:0]   func_b_oe_i,
    // Peripheral inputs and interrupt
    output logic      [31:0]   func_in_o,       // Pin level to both functions
    output logic               irq_o            // Unmasked change pending
);

    // ************************************************************
    // Bus decode
    // ************************************************************

    pioc_top_s st_q;                              // Registered state
    pioc_top_s st_d;                              // Next state

    logic        wr_cyc;                           // Write taken this edge
    logic        rd_cyc;                           // Read taken this edge
    logic        setup_rd;                         // Read setup cycle

    // Zero wait states keep the slave simple; data is prepared in setup
    assign pready   = 1'b1;
    assign wr_cyc   = psel & penable & pwrite;
    assign rd_cyc   = psel & penable & ~pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;

    // Turn a write to one address into a full-width strobe
    function automatic logic [31:0] wr_at(input logic [AW-1:0] ofs);
        wr_at = (wr_cyc && paddr == ofs) ? pwdata : 32'h0000_0000;
    endfunction

    // ************************************************************
    // Status registers
    // ************************************************************

    logic [31:0] owner_raw;                        // Stored owner bits
    logic [31:0] owner;                            // Owner as seen by logic
    logic [31:0] drive_stat;                       // Output enable status
    logic [31:0] filt_stat;                        // Glitch filter status
    logic [31:0] level_stat;                       // Driven levels
    logic [31:0] chg_mask;                         // Change interrupt mask
    logic [31:0] mdrv_stat;                        // Multi-drive status
    logic [31:0] pullup_stat;                      // 1 = pull-up off
    logic [31:0] ab_stat;                          // 1 = function B
    logic [31:0] dwr_mask;                         // Direct write mask
    logic [31:0] dwr_load;                         // Direct write load enable
    logic [31:0] pin_level;                        // Sampled pin levels
    logic [31:0] change;                           // Change pulses

    // Only muxed lines may change owner; others stay with the controller
    pioc_setclr_reg #(.RST_VAL(OWNER_RST)) u_owner (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .set_i  (wr_at(IO_SELECT_OFS) & LINE_MUXED_MASK),
        .clr_i  (wr_at(HAND_OVER_OFS) & LINE_MUXED_MASK),
        .wmask_i(32'h0000_0000),
        .wdata_i(32'h0000_0000),
        .val_o  (owner_raw)
    );
    assign owner = owner_raw | ~LINE_MUXED_MASK;

    // Output enable, writable whoever owns the line
    pioc_setclr_reg #(.RST_VAL(ZERO_RST)) u_drive (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .set_i  (wr_at(DRIVE_EN_OFS)),
        .clr_i  (wr_at(DRIVE_DIS_OFS)),
        .wmask_i(32'h0000_0000),
        .wdata_i(32'h0000_0000),
        .val_o  (drive_stat)
    );

    // Glitch filter selection
    pioc_setclr_reg #(.RST_VAL(ZERO_RST)) u_filt (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .set_i  (wr_at(FILT_EN_OFS)),
        .clr_i  (wr_at(FILT_DIS_OFS)),
        .wmask_i(32'h0000_0000),
        .wdata_i(32'h0000_0000),
        .val_o  (filt_stat)
    );

    // Driven level, by set/clear or by a masked direct write
    assign dwr_load = (wr_cyc && paddr == LEVEL_STAT_OFS) ? dwr_mask
                                                           : 32'h0000_0000;
    pioc_setclr_reg #(.RST_VAL(ZERO_RST)) u_level (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .set_i  (wr_at(LEVEL_SET_OFS)),
        .clr_i  (wr_at(LEVEL_CLR_OFS)),
        .wmask_i(dwr_load),
        .wdata_i(pwdata),
        .val_o  (level_stat)
    );

    // Direct write mask, blocked on every line after reset
    pioc_setclr_reg #(.RST_VAL(ZERO_RST)) u_dwr (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .set_i  (wr_at(DWR_EN_OFS)),
        .clr_i  (wr_at(DWR_DIS_OFS)),
        .wmask_i(32'h0000_0000),
        .wdata_i(32'h0000_0000),
        .val_o  (dwr_mask)
    );

    // Change interrupt mask
    pioc_setclr_reg #(.RST_VAL(ZERO_RST)) u_chgmask (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .set_i  (wr_at(CHG_EN_OFS)),
        .clr_i  (wr_at(CHG_DIS_OFS)),
        .wmask_i(32'h0000_0000),
        .wdata_i(32'h0000_0000),
        .val_o  (chg_mask)
    );

    // Multi-drive selection, disabled after reset
    pioc_setclr_reg #(.RST_VAL(ZERO_RST)) u_mdrv (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .set_i  (wr_at(MDRV_EN_OFS)),
        .clr_i  (wr_at(MDRV_DIS_OFS)),
        .wmask_i(32'h0000_0000),
        .wdata_i(32'h0000_0000),
        .val_o  (mdrv_stat)
    );

    // Pull-up status: the disable register sets, the enable register clears
    pioc_setclr_reg #(.RST_VAL(ZERO_RST)) u_pullup (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .set_i  (wr_at(PULLUP_DIS_OFS)),
        .clr_i  (wr_at(PULLUP_EN_OFS)),
        .wmask_i(32'h0000_0000),
        .wdata_i(32'h0000_0000),
        .val_o  (pullup_stat)
    );

    // Function A/B choice, writable in any ownership
    pioc_setclr_reg #(.RST_VAL(ZERO_RST)) u_ab (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .set_i  (wr_at(FUNC_B_OFS)),
        .clr_i  (wr_at(FUNC_A_OFS)),
        .wmask_i(32'h0000_0000),
        .wdata_i(32'h0000_0000),
        .val_o  (ab_stat)
    );

    // ************************************************************
    // Input sampling
    // ************************************************************

    // Sampling halts with the controller clock; configuration does not
    pioc_in_sample u_smp (
        .mclk_i   (mclk_i),
        .rstn_i   (rstn_i),
        .smp_en_i (per_clk_en_i),
        .filt_en_i(filt_stat),
        .pad_in_i (pad_in_i),
        .level_o  (pin_level),
        .change_o (change)
    );

    // ************************************************************
    // Pad drive
    // ************************************************************

    logic [31:0] func_oe;                          // Chosen function enable
    logic [31:0] func_out;                         // Chosen function level
    logic [31:0] line_oe;                          // Owner's enable
    logic [31:0] line_out;                         // Owner's level

    // The A/B choice steers only the outgoing path
    assign func_oe   = (ab_stat & func_b_oe_i)  | (~ab_stat & func_a_oe_i);
    assign func_out  = (ab_stat & func_b_out_i) | (~ab_stat & func_a_out_i);
    assign func_in_o = pad_in_i;

    // A peripheral owns both enable and level of its lines
    assign line_oe  = (owner & drive_stat) | (~owner & func_oe);
    assign line_out = (owner & level_stat) | (~owner & func_out);

    // Multi-drive lines only pull low; a high level releases the pad
    assign pad_oe_n_o  = ~(line_oe & (~mdrv_stat | ~line_out));
    assign pad_out_o   = line_out & ~mdrv_stat;
    assign pullup_en_o = ~pullup_stat;

    // ************************************************************
    // Read mux, change flags and interrupt
    // ************************************************************

    // Set/clear registers read as zero; unmapped addresses flag an error
    always_comb begin
        st_d        = st_q;
        // New changes win over a clear-on-read in the same edge
        st_d.chg_stat = ((rd_cyc && paddr == CHG_STAT_OFS) ? 32'h0000_0000
                                                           : st_q.chg_stat)
                        | change;
        // Only a running controller clock raises the interrupt
        st_d.irq    = per_clk_en_i & (|(st_d.chg_stat & chg_mask));
        if (setup_rd || (psel && !penable)) begin
            st_d.slverr = 1'b0;
            st_d.rdata  = 32'h0000_0000;
            unique case (paddr)
                OWNER_STAT_OFS:   st_d.rdata = owner;
                DRIVE_STAT_OFS:   st_d.rdata = drive_stat;
                FILT_STAT_OFS:    st_d.rdata = filt_stat;
                LEVEL_STAT_OFS:   st_d.rdata = level_stat;
                PIN_LEVEL_OFS:    st_d.rdata = pin_level;
                CHG_MASK_OFS:     st_d.rdata = chg_mask;
                CHG_STAT_OFS:     st_d.rdata = st_d.chg_stat;
                MDRV_STAT_OFS:    st_d.rdata = mdrv_stat;
                PULLUP_STAT_OFS:  st_d.rdata = pullup_stat;
                FUNC_AB_STAT_OFS: st_d.rdata = ab_stat;
                DWR_MASK_OFS:     st_d.rdata = dwr_mask;
                // Write-only set and clear addresses
                IO_SELECT_OFS, HAND_OVER_OFS, DRIVE_EN_OFS, DRIVE_DIS_OFS,
                FILT_EN_OFS, FILT_DIS_OFS, LEVEL_SET_OFS, LEVEL_CLR_OFS,
                CHG_EN_OFS, CHG_DIS_OFS, MDRV_EN_OFS, MDRV_DIS_OFS,
                PULLUP_DIS_OFS, PULLUP_EN_OFS, FUNC_A_OFS, FUNC_B_OFS,
                DWR_EN_OFS, DWR_DIS_OFS: st_d.rdata = 32'h0000_0000;
                default:          st_d.slverr = 1'b1;
            endcase
            // Read data only on reads; the error flag covers both directions
            if (pwrite) begin
                st_d.rdata = 32'h0000_0000;
            end
        end
    end

    // One register stage for all top-level state
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Read data comes straight from flip-flops; the error is gated by psel and penable
    assign prdata  = st_q.rdata;
    assign pslverr = st_q.slverr & psel & penable;
    assign irq_o   = st_q.irq;

endmodule

/* dv/pioc_props.sv */
// Port checker for pioc_top, bound to each instance.
// Assumes the one mclk_i domain with its synchronous reset.
`timescale 1ns/1ns
module pioc_props
    import pioc_pkg::*;
(
    input wire logic          mclk_i,
    input wire logic          rstn_i,
    input wire logic          per_clk_en_i,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic [31:0]   pad_in_i,
    input wire logic [31:0]   pullup_en_o,
    input wire logic [31:0]   func_in_o,
    input wire logic          irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // Access phase at one offset
    sequence s_acc(logic [AW-1:0] a, logic w);
        psel && penable && (pwrite == w) && (paddr == a);
    endsequence
    // Pads quiet long enough that no change is still in the sampler
    sequence s_calm;
        (pad_in_i == $past(pad_in_i)) && ($past(pad_in_i) == $past(pad_in_i, 2)) &&
        ($past(pad_in_i, 2) == $past(pad_in_i, 3)) && ($past(pad_in_i, 3) == $past(pad_in_i, 4));
    endsequence
    chk_pullup_off: assert property (s_acc(PULLUP_DIS_OFS, 1'b1) |=>
        (pullup_en_o & $past(pwdata)) == '0) else $error("pull-up still on");
    chk_pullup_on: assert property (s_acc(PULLUP_EN_OFS, 1'b1) |=>
        (pullup_en_o & $past(pwdata)) == $past(pwdata)) else $error("pull-up still off");
    chk_input_pass: assert property (func_in_o == pad_in_i)
        else $error("function input not pad");
    chk_reset_vals: assert property ($rose(rstn_i) |->
        (pullup_en_o == '1) && !irq_o) else $error("bad state after reset");
    chk_wo_read: assert property (s_acc(LEVEL_SET_OFS, 1'b0) |-> prdata == '0)
        else $error("write-only read nonzero");
    chk_irq_gated: assert property (!per_clk_en_i && !$past(per_clk_en_i) |-> !irq_o)
        else $error("interrupt while gated");
    chk_irq_cause: assert property ($rose(irq_o) |-> $past(per_clk_en_i))
        else $error("interrupt rose while gated");
    chk_chg_clear: assert property (s_acc(CHG_STAT_OFS, 1'b0) ##0 s_calm |-> ##2 !irq_o)
        else $error("interrupt kept after read");
endmodule
bind pioc_top pioc_props i_props (.mclk_i(mclk_i), .rstn_i(rstn_i), .per_clk_en_i(per_clk_en_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pad_in_i(pad_in_i), .pullup_en_o(pullup_en_o), .func_in_o(func_in_o),
    .irq_o(irq_o));

/* dv/pioc_pad_model.sv */
// Pads and the two peripheral functions beyond the controller.
// Assumes an outside driver on every line; the controller wins a clash.
`timescale 1ns/1ns
module pioc_pad_model
    import pioc_pkg::*;
#(
    parameter logic [31:0] FA_OUT = 32'h5555_5555,  // Function A levels
    parameter logic [31:0] FA_OE  = 32'hFFFF_FFFF,  // Function A drive
    parameter logic [31:0] FB_OUT = 32'h0000_3C00,  // Function B levels
    parameter logic [31:0] FB_OE  = 32'h0000_F0F0   // Function B drive
) (
    input  wire logic [31:0] pad_out_i,
    input  wire logic [31:0] pad_oe_n_i,
    input  wire logic [31:0] ext_val_i,
    output logic      [31:0] pad_o,
    output logic      [31:0] fa_out_o,
    output logic      [31:0] fa_oe_o,
    output logic      [31:0] fb_out_o,
    output logic      [31:0] fb_oe_o
);
    // Released lines show the outside level, never a stale driven one
    assign pad_o    = (pad_out_i & ~pad_oe_n_i) | (ext_val_i & pad_oe_n_i);
    assign fa_out_o = FA_OUT;
    assign fa_oe_o  = FA_OE;
    assign fb_out_o = FB_OUT;
    assign fb_oe_o  = FB_OE;
endmodule

/* dv/tb_parallel_io_line_controller.sv */
// Self-checking bench: APB register sequences against pioc_top and its pads.
// Assumes the pad model drives every released line from ext_val.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, (e), (g)); end end
module tb_parallel_io_line_controller
    import pioc_pkg::*;
();
    logic          mclk_i, rstn_i, per_clk_en_i, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic [AW-1:0] paddr;
    logic [31:0]   pwdata, prdata, pad_in, pad_out, pad_oe_n, pullup_en, func_in, ext_val, rdat;
    logic [31:0]   fa_out, fa_oe, fb_out, fb_oe;
    int            n_mismatch, comparisons, n;
    localparam logic [31:0] HO = 32'h0001_FF00;  // Lines handed to peripherals
    localparam logic [31:0] OWN_EXP = (OWNER_RST & ~(HO & LINE_MUXED_MASK)) | ~LINE_MUXED_MASK;
    localparam logic [AW-1:0] RST_A [6] = '{PULLUP_STAT_OFS, OWNER_STAT_OFS, FUNC_AB_STAT_OFS,
        DWR_MASK_OFS, DRIVE_STAT_OFS, LEVEL_SET_OFS};
    localparam logic [31:0] RST_V [6] = '{ZERO_RST, OWNER_RST, ZERO_RST, ZERO_RST, ZERO_RST, ZERO_RST};
    pioc_top i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .per_clk_en_i(per_clk_en_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in_i(pad_in), .pad_out_o(pad_out),
        .pad_oe_n_o(pad_oe_n), .pullup_en_o(pullup_en), .func_a_out_i(fa_out), .func_a_oe_i(fa_oe),
        .func_b_out_i(fb_out), .func_b_oe_i(fb_oe), .func_in_o(func_in), .irq_o(irq));
    pioc_pad_model i_pads (.pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n), .ext_val_i(ext_val),
        .pad_o(pad_in), .fa_out_o(fa_out), .fa_oe_o(fa_oe), .fb_out_o(fb_out), .fb_oe_o(fb_oe));
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    task automatic stop_test();
        if ((n_mismatch == 0) && (comparisons > 0))
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One APB transfer; answer is taken where pready is seen high
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk_i);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while ((pready !== 1'b1) && (k < 20)) begin
            @(posedge mclk_i);
            k++;
        end
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
        if (k == 20) begin
            n_mismatch++;
            stop_test();
        end
    endtask
    task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rdat)
    endtask
    initial begin
        {rstn_i, per_clk_en_i, psel, penable, pwrite} = 5'b01000;
        {paddr, pwdata} = '0;
        ext_val = 32'h1234_5600;
        repeat (6) @(posedge mclk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 6; i++)
            rchk("reset", RST_A[i], RST_V[i]);
        apb(1'b1, PULLUP_DIS_OFS, 32'hFFFF_0000);
        apb(1'b1, PULLUP_EN_OFS, 32'h0F00_0000);
        rchk("pullup", PULLUP_STAT_OFS, 32'hF0FF_0000);
        `CHK("pullup_pin", 32'h0F00_FFFF, pullup_en)
        apb(1'b1, DRIVE_EN_OFS, 32'h0000_00FF);
        apb(1'b1, LEVEL_SET_OFS, 32'h0000_000F);
        apb(1'b1, LEVEL_STAT_OFS, 32'hFFFF_FFFF);
        apb(1'b1, DWR_EN_OFS, 32'h0000_00F0);
        apb(1'b1, LEVEL_STAT_OFS, 32'h0000_00A0);
        rchk("level", LEVEL_STAT_OFS, 32'h0000_00AF);
        rchk("pin", PIN_LEVEL_OFS, 32'h1234_56AF);
        `CHK("oe_n", 32'hFFFF_FF00, pad_oe_n)
        apb(1'b1, FUNC_B_OFS, 32'h0000_FF00);
        apb(1'b1, HAND_OVER_OFS, HO);
        apb(1'b1, DRIVE_EN_OFS, 32'h0000_FF00);
        rchk("ab", FUNC_AB_STAT_OFS, 32'h0000_FF00);
        rchk("owner", OWNER_STAT_OFS, OWN_EXP);
        rchk("drive", DRIVE_STAT_OFS, 32'h0000_FFFF);
        `CHK("b_oe", ~i_pads.FB_OE[15:8], pad_oe_n[15:8])
        `CHK("a_out", {i_pads.FA_OUT[16], 1'b0}, {pad_out[16], pad_oe_n[16]})
        apb(1'b0, CHG_STAT_OFS, 32'h0000_0000);
        per_clk_en_i <= 1'b0;
        ext_val <= 32'h1224_5600;
        apb(1'b1, CHG_EN_OFS, 32'h0010_0000);
        rchk("mask", CHG_MASK_OFS, 32'h0010_0000);
        rchk("frozen", PIN_LEVEL_OFS, 32'h1235_36AF);
        `CHK("irq_off", 1'b0, irq)
        per_clk_en_i <= 1'b1;
        n = 0;
        while ((irq !== 1'b1) && (n < 20)) begin
            @(negedge mclk_i);
            n++;
        end
        `CHK("irq_on", 1'b1, irq)
        if (n == 20) stop_test();
        rchk("chg", CHG_STAT_OFS, 32'h0010_0000);
        rchk("chg_clr", CHG_STAT_OFS, 32'h0000_0000);
        `CHK("irq_clr", 1'b0, irq)
        apb(1'b1, MDRV_EN_OFS, 32'h0000_0011);
        repeat (2) @(posedge mclk_i);
        `CHK("mdrv", 4'b0100, {pad_oe_n[4], pad_oe_n[0], pad_out[4], pad_out[0]})
        rchk("pin_md", PIN_LEVEL_OFS, 32'h1225_36AE);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        `CHK("unmapped", {1'b1, 32'h0000_0000}, {rerr, rdat})
        stop_test();
    end
endmodule
